// ===== hw/rfc_pkg.sv
// shared constants for the receive fabric clock interface
package rfc_pkg;
	localparam int SLOT_W     = 10;
	localparam int BYTE_W     = 8;
	localparam int INT_SLOTS  = 4;
	localparam int IF_SLOTS   = 8;
	localparam int OUT_W      = 128;
	localparam int USED_W     = 64;
	localparam int EXT_W      = 16;
	localparam int EXT_LOW_B  = 8;
	localparam int EXT_HIGH_B = 9;
	localparam int SLOT_CNT_W = 4;
	localparam int DW_W       = 7;
	localparam logic [DW_W-1:0] DW_16 = 7'h10;
	localparam logic [DW_W-1:0] DW_20 = 7'h14;
	localparam logic [DW_W-1:0] DW_32 = 7'h20;
	localparam logic [DW_W-1:0] DW_40 = 7'h28;
	localparam logic [DW_W-1:0] DW_64 = 7'h40;
	localparam logic [DW_W-1:0] DW_80 = 7'h50;
	localparam logic [SLOT_CNT_W-1:0] NB_2 = 4'h2;
	localparam logic [SLOT_CNT_W-1:0] NB_4 = 4'h4;
	localparam logic [SLOT_CNT_W-1:0] NB_8 = 4'h8;
	localparam logic INT_2BYTE = 1'b0;
	localparam logic INT_4BYTE = 1'b1;
	localparam logic STAGE_ON  = 1'b1;
	typedef enum logic [1:0] {
		PH_FIRST  = 2'b01,
		PH_SECOND = 2'b10
	} rfc_phase_e;
endpackage

// ===== hw/rfc_rx_fabric_if.sv
// receive fabric interface: width gearing, byte extension and staging

`timescale 1ns/10ps
module rfc_rx_fabric_if (
	// clock and reset
	input  wire logic                                                 core_clk,
	input  wire logic                                                 arst_n,
	// configuration
	input  wire logic [rfc_pkg::DW_W-1:0]                             dataWidthCfg,
	input  wire logic                                                 internal_width_cfg,
	input  wire logic                                                 staging_flop_cfg,
	input  wire logic                                                 decoder_enable,
	// internal datapath word, slot 0 received first
	input  wire logic [rfc_pkg::INT_SLOTS*rfc_pkg::SLOT_W-1:0]        pcsWord,
	// fabric side
	output logic                                                      ifaceEdge,
	output logic [rfc_pkg::OUT_W-1:0]                                 rx_word_out,
	output logic [rfc_pkg::EXT_W-1:0]                                 rx_extend_low,
	output logic [rfc_pkg::EXT_W-1:0]                                 rx_extend_high,
	output logic                                                      reserved_extension_out
);
	// slot field widths of the internal and interface words
	localparam int IW = rfc_pkg::INT_SLOTS * rfc_pkg::SLOT_W;
	localparam int AW = rfc_pkg::IF_SLOTS * rfc_pkg::SLOT_W;
	// slots used by the 2-byte internal path
	localparam int HW = int'(rfc_pkg::NB_2) * rfc_pkg::SLOT_W;

	// configuration, taken on interface edges
	logic [rfc_pkg::DW_W-1:0] dw_r, dw_nxt;
	logic                     iw_r, iw_nxt;
	logic                     stg_r, stg_nxt;
	logic                     dec_r, dec_nxt;
	// gearing state
	rfc_pkg::rfc_phase_e      phase_r, phase_nxt;
	logic [IW-1:0]            stage_r, stage_nxt;
	logic [AW-1:0]            acc_r, acc_nxt;
	logic [rfc_pkg::USED_W-1:0] data_r, data_nxt;
	logic [rfc_pkg::IF_SLOTS-1:0] lo_r, lo_nxt, hi_r, hi_nxt;

	logic [rfc_pkg::SLOT_CNT_W-1:0] intBytes, ifBytes;
	logic                     doubleRate, rawMode, extWidth;
	logic [IW-1:0]            inWord;
	logic [AW-1:0]            slotsOut;
	logic [rfc_pkg::USED_W-1:0] splitData;
	logic [rfc_pkg::IF_SLOTS-1:0] splitLo, splitHi;

	always_comb begin
		intBytes = (iw_r == rfc_pkg::INT_4BYTE) ? rfc_pkg::NB_4 : rfc_pkg::NB_2;
		case (dw_r)
			rfc_pkg::DW_16, rfc_pkg::DW_20: begin
				ifBytes = rfc_pkg::NB_2;
			end
			rfc_pkg::DW_32, rfc_pkg::DW_40: begin
				ifBytes = rfc_pkg::NB_4;
			end
			default: begin
				ifBytes = rfc_pkg::NB_8;
			end
		endcase
		// only the 20, 40 and 80 settings carry extension bits
		extWidth   = (dw_r == rfc_pkg::DW_20) || (dw_r == rfc_pkg::DW_40) || (dw_r == rfc_pkg::DW_80);
		rawMode    = ~dec_r & extWidth;
		doubleRate = (ifBytes != intBytes);
		// staging flop only when widths match
		inWord     = (!doubleRate && stg_r == rfc_pkg::STAGE_ON) ? stage_r : pcsWord;
		// double rate: the interface clock ticks every second internal cycle
		ifaceEdge  = !doubleRate || (phase_r == rfc_pkg::PH_SECOND);
	end

	// assemble interface slots: first internal word fills the low slots
	always_comb begin
		slotsOut = '0;
		if (!doubleRate) begin
			// equal widths: one internal word per interface word
			slotsOut[IW-1:0] = inWord;
			if (intBytes == rfc_pkg::NB_2) begin
				slotsOut[IW-1:HW] = '0;
			end
		end else if (intBytes == rfc_pkg::NB_2) begin
			// two 2-byte words form one 4-byte word
			slotsOut[HW-1:0]  = acc_r[HW-1:0];
			slotsOut[IW-1:HW] = inWord[HW-1:0];
		end else begin
			// two 4-byte words form one 8-byte word
			slotsOut[IW-1:0]  = acc_r[IW-1:0];
			slotsOut[AW-1:IW] = inWord;
		end
	end

	// one splitter per interface slot
	genvar g;
	generate
		for (g = 0; g < rfc_pkg::IF_SLOTS; g++) begin : gSlot
			rfc_slot_split uSplit (
				.slot     (slotsOut[g*rfc_pkg::SLOT_W +: rfc_pkg::SLOT_W]),
				.rawMode  (rawMode),
				.slotUsed (rfc_pkg::SLOT_CNT_W'(g) < ifBytes),
				.dataByte (splitData[g*rfc_pkg::BYTE_W +: rfc_pkg::BYTE_W]),
				.extLow   (splitLo[g]),
				.extHigh  (splitHi[g])
			);
		end
	endgenerate

	// configuration group: new settings take effect only on an interface edge
	always_comb begin
		dw_nxt  = dw_r;
		iw_nxt  = iw_r;
		stg_nxt = stg_r;
		dec_nxt = dec_r;
		if (ifaceEdge) begin
			dw_nxt  = dataWidthCfg;
			iw_nxt  = internal_width_cfg;
			stg_nxt = staging_flop_cfg;
			dec_nxt = decoder_enable;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			dw_r  <= rfc_pkg::DW_16;
			iw_r  <= rfc_pkg::INT_2BYTE;
			stg_r <= 1'b0;
			dec_r <= 1'b0;
		end else begin
			dw_r  <= dw_nxt;
			iw_r  <= iw_nxt;
			stg_r <= stg_nxt;
			dec_r <= dec_nxt;
		end
	end

	// gearing group: phase restarts at reset, so word pairs align to its release
	always_comb begin
		phase_nxt = phase_r;
		acc_nxt   = acc_r;
		stage_nxt = pcsWord;
		if (doubleRate) begin
			case (phase_r)
				rfc_pkg::PH_FIRST: begin
					// first word of a pair waits for its partner
					acc_nxt[IW-1:0] = inWord;
					phase_nxt       = rfc_pkg::PH_SECOND;
				end
				rfc_pkg::PH_SECOND: begin
					phase_nxt = rfc_pkg::PH_FIRST;
				end
				default: begin
					phase_nxt = rfc_pkg::PH_FIRST;
				end
			endcase
		end else begin
			phase_nxt = rfc_pkg::PH_FIRST;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_r <= rfc_pkg::PH_FIRST;
			acc_r   <= '0;
			stage_r <= '0;
		end else begin
			phase_r <= phase_nxt;
			acc_r   <= acc_nxt;
			stage_r <= stage_nxt;
		end
	end

	// output group: words and extension bits hold between interface edges
	always_comb begin
		data_nxt = data_r;
		lo_nxt   = lo_r;
		hi_nxt   = hi_r;
		if (ifaceEdge) begin
			data_nxt = splitData;
			lo_nxt   = splitLo;
			hi_nxt   = splitHi;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			data_r <= '0;
			lo_r   <= '0;
			hi_r   <= '0;
		end else begin
			data_r <= data_nxt;
			lo_r   <= lo_nxt;
			hi_r   <= hi_nxt;
		end
	end

	// upper data half and extension tops stay zero
	always_comb begin
		rx_word_out = {{(rfc_pkg::OUT_W-rfc_pkg::USED_W){1'b0}}, data_r};
		rx_extend_low  = {{(rfc_pkg::EXT_W-rfc_pkg::IF_SLOTS){1'b0}}, lo_r};
		rx_extend_high = {{(rfc_pkg::EXT_W-rfc_pkg::IF_SLOTS){1'b0}}, hi_r};
		// reserved output has no function in this block
		reserved_extension_out = 1'b0;
	end
endmodule

// ===== hw/rfc_slot_split.sv
// splits one 10-bit received slot into its byte and two extension bits
`timescale 1ns/10ps
module rfc_slot_split (
	// slot in
	input  wire logic [rfc_pkg::SLOT_W-1:0] slot,
	input  wire logic                       rawMode,
	input  wire logic                       slotUsed,
	// split out
	output logic      [rfc_pkg::BYTE_W-1:0] dataByte,
	output logic                            extLow,
	output logic                            extHigh
);
	always_comb begin
		dataByte = slotUsed ? slot[rfc_pkg::BYTE_W-1:0] : '0;
		extLow   = slotUsed & rawMode & slot[rfc_pkg::EXT_LOW_B];
		extHigh  = slotUsed & rawMode & slot[rfc_pkg::EXT_HIGH_B];
	end
endmodule

// ===== tb/rfc_fabric_sink.sv
// fabric consumer model: flags each new interface word
`timescale 1ns/10ps
module rfc_fabric_sink (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// interface
	input wire logic ifaceEdge,
	output logic     fresh_r
);
	logic fresh_nxt;
	always_comb fresh_nxt = ifaceEdge;
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n) fresh_r <= 1'b0;
		else fresh_r <= fresh_nxt;
endmodule

// ===== tb/rfc_rx_fabric_if_bench.sv
// self-checking bench for the receive fabric interface
`timescale 1ns/10ps
module rfc_rx_fabric_if_bench;
	logic         core_clk = 1'b0, arst_n = 1'b0, iCfg, sCfg, dCfg, ifaceEdge, fresh;
	logic [6:0]   wCfg;
	logic [39:0]  pcsWord = 40'h0, w1;
	logic [31:0]  seed = 32'h3EE78BE2;
	logic [127:0] rxWord;
	logic [15:0]  extLo, extHi;
	logic [159:0] expQ[$], note;
	int           fails = 0, checks = 0, cyc = 0;
	always #12.5 core_clk = ~core_clk;
	rfc_rx_fabric_if i_dut (.core_clk, .arst_n, .dataWidthCfg(wCfg), .internal_width_cfg(iCfg),
		.staging_flop_cfg(sCfg), .decoder_enable(dCfg), .pcsWord, .ifaceEdge, .rx_word_out(rxWord),
		.rx_extend_low(extLo), .rx_extend_high(extHi), .reserved_extension_out());
	rfc_fabric_sink i_sink (.core_clk, .arst_n, .ifaceEdge, .fresh_r(fresh));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	function automatic logic [159:0] ex(input logic [79:0] s, input int nb, input logic ext);
		logic [159:0] e = '0;
		for (int k = 0; k < nb; k++) begin
			e[8 * k +: 8] = s[10 * k +: 8];
			e[128 + k] = ext & s[10 * k + 8];
			e[144 + k] = ext & s[10 * k + 9];
		end
		return e;
	endfunction
	task results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task test(input logic [6:0] w, input logic i, s, d);
		logic dbl, ext;
		logic [79:0] sl, mk;
		int m;
		@(negedge core_clk);
		{wCfg, iCfg, sCfg, dCfg, arst_n} = {w, i, s, d, 1'b0};
		repeat (3) @(negedge core_clk);
		arst_n = 1'b1;
		m = i ? 4 : 2;
		mk = i ? 80'hFF_FFFF_FFFF : 80'hF_FFFF;
		dbl = i ? w inside {7'h40, 7'h50} : w inside {7'h20, 7'h28};
		ext = !d && w inside {7'h14, 7'h28, 7'h50};
		for (int n = 0; n < 24; n++) begin
			@(negedge core_clk);
			w1 = pcsWord;
			seed = xs(seed);
			pcsWord = {seed[7:0], xs(seed)};
			sl = dbl ? ((pcsWord & mk) << (10 * m)) | (w1 & mk) : (s ? w1 : pcsWord) & mk;
			if (ifaceEdge && n > 5)
				expQ.push_back(ex(sl, dbl ? 2 * m : m, ext));
		end
		repeat (3) @(negedge core_clk);
		$display("test width %0d done", w);
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			results();
		end
		#2;
		if (fresh && expQ.size() > 0) begin
			note = expQ.pop_front();
			checks++;
			if ({extHi, extLo, rxWord} !== note) begin
				fails++;
				$display("unexpected outputs: expected %h seen %h", note, {extHi, extLo, rxWord});
			end
		end
	end
	initial begin
		test(7'h10, 1'b0, 1'b0, 1'b0);
		test(7'h14, 1'b0, 1'b1, 1'b0);
		test(7'h28, 1'b0, 1'b1, 1'b0);
		test(7'h20, 1'b1, 1'b1, 1'b0);
		test(7'h28, 1'b1, 1'b0, 1'b1);
		test(7'h40, 1'b1, 1'b0, 1'b0);
		test(7'h50, 1'b1, 1'b0, 1'b0);
		test(7'h14, 1'b0, 1'b0, 1'b1);
		results();
	end
endmodule

// ===== tb/rfc_rx_fabric_if_monitor.sv
// assertion checker for the receive fabric interface
`timescale 1ns/10ps
module rfc_rx_fabric_if_monitor (
	// clock and reset
	input wire logic         core_clk,
	input wire logic         arst_n,
	// configuration and data in
	input wire logic [6:0]   dataWidthCfg,
	input wire logic         internal_width_cfg,
	input wire logic         staging_flop_cfg,
	input wire logic         decoder_enable,
	input wire logic [39:0]  pcsWord,
	// fabric side
	input wire logic         ifaceEdge,
	input wire logic [127:0] rx_word_out,
	input wire logic [15:0]  rx_extend_low,
	input wire logic [15:0]  rx_extend_high,
	input wire logic         reserved_extension_out
);
	wire n16 = dataWidthCfg inside {7'h10, 7'h14};
	wire pln = dataWidthCfg inside {7'h10, 7'h20, 7'h40};
	wire eqW = internal_width_cfg ? dataWidthCfg inside {7'h20, 7'h28} : n16;
	wire dbl = internal_width_cfg ? dataWidthCfg inside {7'h40, 7'h50} : dataWidthCfg inside {7'h20, 7'h28};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_eq; eqW [*6]; endsequence
	sequence s_dbl; dbl [*6]; endsequence
	a_upper_zero: assert property (rx_word_out[127:64] == 64'h0)
		else $error("upper data half set");
	a_ext_top: assert property ({rx_extend_high[15:8], rx_extend_low[15:8]} == 16'h0)
		else $error("extension top set");
	a_dec_noext: assert property (decoder_enable [*8] |=> {rx_extend_high, rx_extend_low} == 32'h0)
		else $error("extension with decoder");
	a_plain_noext: assert property (pln [*8] |=> {rx_extend_high, rx_extend_low} == 32'h0)
		else $error("extension at plain width");
	a_narrow_data: assert property (n16 [*8] |=> rx_word_out[127:16] == 112'h0)
		else $error("narrow width data too wide");
	a_edge_equal: assert property (s_eq |-> ifaceEdge)
		else $error("edge missing at equal widths");
	a_edge_toggle: assert property (s_dbl |-> ifaceEdge != $past(ifaceEdge))
		else $error("edge not alternating");
	a_hold_idle: assert property (!ifaceEdge |=> $stable(rx_word_out) && $stable(rx_extend_low))
		else $error("output moved off edge");
	a_reserved_low: assert property (reserved_extension_out == 1'b0)
		else $error("reserved output set");
endmodule
bind rfc_rx_fabric_if rfc_rx_fabric_if_monitor i_mon (.core_clk, .arst_n, .dataWidthCfg, .internal_width_cfg,
	.staging_flop_cfg, .decoder_enable, .pcsWord, .ifaceEdge, .rx_word_out, .rx_extend_low, .rx_extend_high,
	.reserved_extension_out);
